// ### shared/uic_pkg.sv
// Summary of operation
// RQ1: Halt instruction clears the whole status register; core stays stopped until a reset.
// RQ2: Firmware writes zero to reserved status bit 1 and normally one to run.
// RQ3: Status bit 2 mirrors the global interrupt enable; writes there change nothing.
// RQ4: Disable clears, enable sets, return restores flags and sets global enable.
// RQ5: Writing suspend bit 3 stops the core; enabled pending request or bus activity wakes.
// RQ6: A suspend write is ignored while the bus shows non-idle activity.
// RQ7: Power-on reset sets status bit 4 so firmware can tell resets apart.
// RQ8: End of a 12 to 16 us single-ended zero sets bit 5 and raises bus reset.
// RQ9: Watchdog expiry after at least 8 ms without clear resets and sets bit 6.
// RQ10: Bit 7 shows a recognised pending request; acknowledge clears it until a new one.
// RQ11: Power-up loads status with 00010001.
// RQ12: Start-up watchdog fires unless an upstream single-ended zero aborts it first.
// RQ13: Watchdog reset loads 01XX0001, keeping power-on and bus reset flags.
// RQ14: Global enable register bits 0,1,2,4,5,6 enable their sources when one.
// RQ15: Endpoint enable register bits 0 to 4 mask the five endpoint sources.
// RQ16: Each source has its own pending flop held until serviced or reset.
// RQ17: Only enabled pending sources request; taken after the current instruction completes.
// RQ18: Acknowledge clears global enable, then the pending flop, then calls the vector.
// RQ19: The acknowledge call pushes program counter, carry and zero onto the stack.
// RQ20: Nesting is allowed whenever firmware re-enables interrupts inside a routine.
// RQ21: Lower vector number wins; bus reset 0x0002 highest, two-wire 0x0018 lowest.
// RQ22: The acknowledge call takes 10 clock cycles after the instruction ends.
// RQ23: Reserved enable bits ignore writes and read zero; pending flops clear on reset.
package uic_pkg;
    // ==========================================================
    // Register map and fields
    localparam logic [7:0] ADDR_GLOBAL_EN = 8'h20;
    localparam logic [7:0] ADDR_EP_EN     = 8'h21;
    localparam logic [7:0] ADDR_VECTOR    = 8'h23;
    localparam logic [7:0] ADDR_STATUS    = 8'hFF;
    localparam int ST_RUN    = 0;
    localparam int ST_GIE    = 2;
    localparam int ST_SUSP   = 3;
    localparam int ST_POR    = 4;
    localparam int ST_BUSRST = 5;
    localparam int ST_WDR    = 6;
    localparam int ST_PEND   = 7;
    localparam logic [7:0] STATUS_POR_VAL = 8'h11;
    localparam logic [7:0] GEN_EN_MASK    = 8'h77;
    localparam logic [7:0] EP_EN_MASK     = 8'h1F;
    localparam logic [7:0] EN_RESET_VAL   = 8'h00;
    // ==========================================================
    // Sources, index 0 is vector 1 (highest priority)
    localparam int NUM_SRC    = 12;
    localparam int SRC_BUSRST = 0;
    // ==========================================================
    // Timing at 40 MHz
    localparam int CLK_MHZ            = 40;
    localparam int BUS_RST_MIN_NS     = 12000;
    localparam int BUS_RST_MIN_CYC    = (BUS_RST_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int WDT_TIMEOUT_US     = 8000;
    localparam int WDT_CYCLES_DEF     = WDT_TIMEOUT_US * CLK_MHZ;
    localparam int CALL_CYCLES        = 10;
    // ==========================================================
    // Acknowledge sequencer
    typedef enum logic [1:0] {
        UIC_IDLE    = 2'b00,
        UIC_DISABLE = 2'b01,
        UIC_CALL    = 2'b10
    } uic_ack_t;
endpackage

// ### logic/uic_irq_ctrl.sv
`timescale 1ns/1ps
module uic_irq_ctrl import uic_pkg::*; #(
    parameter int WDT_CYCLES = WDT_CYCLES_DEF
) (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_io_wr,
    input  wire logic        i_io_rd,
    input  wire logic [7:0]  i_io_addr,
    input  wire logic [7:0]  i_io_wdata,
    output logic      [7:0]  o_io_rdata,
    input  wire logic        i_instr_done,
    input  wire logic        i_irq_off_instr,
    input  wire logic        i_irq_on_instr,
    input  wire logic        i_irq_return_instr,
    input  wire logic        i_halt_instr,
    input  wire logic        i_wdt_clear,
    input  wire logic [13:0] i_pc,
    input  wire logic        i_carry_flag,
    input  wire logic        i_zero_flag,
    input  wire logic [11:0] i_src_event,
    input  wire logic        i_se0,
    input  wire logic        i_bus_active,
    input  wire logic        i_startup_active,
    output logic             o_run,
    output logic             o_suspend,
    output logic             o_ack_busy,
    output logic             o_stack_push,
    output logic      [15:0] o_stack_word,
    output logic             o_call_strobe,
    output logic      [13:0] o_call_vector,
    output logic             o_wdt_reset,
    output logic             o_bus_reset
);
    // ==========================================================
    // Pin synchroniser and bus reset detector
    logic                  se0_meta_r, se0_sync_r;
    logic [8:0]            se0_cnt_r, se0_cnt_nxt;
    logic                  se0_seen_r, se0_seen_nxt;
    logic                  bus_evt_r, bus_evt_nxt;

    // Two flops before anything looks at the pin
    always_ff @(posedge i_clk) begin
        se0_meta_r <= i_se0;
        se0_sync_r <= se0_meta_r;
    end

    // RQ8: bus reset ends
    always_comb begin
        se0_cnt_nxt  = se0_cnt_r;
        se0_seen_nxt = se0_seen_r;
        bus_evt_nxt  = 1'b0;
        if (se0_sync_r) begin
            if (se0_cnt_r == 9'(BUS_RST_MIN_CYC - 1)) begin
                se0_seen_nxt = 1'b1;
            end else begin
                se0_cnt_nxt = se0_cnt_r + 9'h001;
            end
        end else begin
            bus_evt_nxt  = se0_seen_r;  // Flag only when the zero lifts
            se0_cnt_nxt  = 9'h000;
            se0_seen_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            se0_cnt_r  <= 9'h000;
            se0_seen_r <= 1'b0;
            bus_evt_r  <= 1'b0;
        end else begin
            se0_cnt_r  <= se0_cnt_nxt;
            se0_seen_r <= se0_seen_nxt;
            bus_evt_r  <= bus_evt_nxt;
        end
    end

    // ==========================================================
    // Watchdog
    logic [19:0]           wdt_cnt_r, wdt_cnt_nxt;
    logic                  wdt_fire_r, wdt_fire_nxt;

    // RQ9: timeout fires reset
    always_comb begin
        wdt_fire_nxt = 1'b0;
        wdt_cnt_nxt  = wdt_cnt_r + 20'h0_0001;
        // RQ12: start-up abort
        if (i_wdt_clear || wdt_fire_r || (i_startup_active && se0_sync_r)) begin
            wdt_cnt_nxt = 20'h0_0000;
        end else if (wdt_cnt_r == 20'(WDT_CYCLES - 1)) begin
            wdt_cnt_nxt  = 20'h0_0000;
            wdt_fire_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wdt_cnt_r  <= 20'h0_0000;
            wdt_fire_r <= 1'b0;
        end else begin
            wdt_cnt_r  <= wdt_cnt_nxt;
            wdt_fire_r <= wdt_fire_nxt;
        end
    end

    // ==========================================================
    // Enables, pending flops, status and acknowledge
    logic [7:0]            gen_en_r, gen_en_nxt;
    logic [7:0]            ep_en_r, ep_en_nxt;
    logic [NUM_SRC-1:0]    pend_r, pend_nxt, pend_clr, src_evt, en_vec, req, pend_keep;
    logic                  run_r, run_nxt, gie_r, gie_nxt, susp_r, susp_nxt;
    logic                  por_r, por_nxt, busrst_r, busrst_nxt;
    logic                  wdr_r, wdr_nxt, irqp_r, irqp_nxt;
    uic_ack_t              state_r, state_nxt;
    logic [3:0]            cnt_r, cnt_nxt, win_r, win_nxt, win_now;
    logic [7:0]            rdata_r, rdata_nxt, status_w;
    logic                  push_r, push_nxt, call_r, call_nxt;
    logic [15:0]           word_r, word_nxt;
    logic [13:0]           vec_r, vec_nxt;

    // RQ14: global enable map
    // RQ15: endpoint enable map
    assign en_vec  = {gen_en_r[6:4], 1'b0, ep_en_r[4:0], gen_en_r[2:0]};
    assign src_evt = i_src_event | {{(NUM_SRC-1){1'b0}}, bus_evt_r};
    // RQ17: enabled requests
    assign req     = pend_r & en_vec;
    // RQ3: enable sense view
    assign status_w = {irqp_r, wdr_r, busrst_r, por_r, susp_r, gie_r, 1'b0, run_r};

    // RQ21: lowest index wins
    always_comb begin
        win_now = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                win_now = 4'(i);
            end
        end
    end

    // Next-state for the controller core
    always_comb begin
        gen_en_nxt = gen_en_r;
        ep_en_nxt  = ep_en_r;
        run_nxt    = run_r;
        gie_nxt    = gie_r;
        susp_nxt   = susp_r;
        por_nxt    = por_r;
        busrst_nxt = busrst_r;
        wdr_nxt    = wdr_r;
        irqp_nxt   = irqp_r;
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        win_nxt    = win_r;
        pend_clr   = '0;
        push_nxt   = 1'b0;
        call_nxt   = 1'b0;
        word_nxt   = word_r;
        vec_nxt    = vec_r;
        rdata_nxt  = rdata_r;
        // CPU enable instructions
        if (state_r == UIC_IDLE) begin
            // RQ4: enable control
            if (i_irq_off_instr) begin
                gie_nxt = 1'b0;
            end else if (i_irq_on_instr || i_irq_return_instr) begin
                // RQ20: re-enable allows nesting
                gie_nxt = 1'b1;
            end
        end
        // Acknowledge sequencer
        case (state_r)
            UIC_IDLE: begin
                // RQ17: after instruction ends
                if (i_instr_done && gie_r && (|req) && run_r && !susp_r) begin
                    // RQ18: disable first
                    gie_nxt   = 1'b0;
                    irqp_nxt  = 1'b0;
                    win_nxt   = win_now;
                    state_nxt = UIC_DISABLE;
                end
            end
            UIC_DISABLE: begin
                // RQ18: then clear pending
                pend_clr[win_r] = 1'b1;
                // RQ19: push PC and flags
                push_nxt  = 1'b1;
                word_nxt  = {i_pc, i_carry_flag, i_zero_flag};
                cnt_nxt   = 4'(CALL_CYCLES - 2);
                state_nxt = UIC_CALL;
            end
            UIC_CALL: begin
                // RQ22: ten-cycle call
                if (cnt_r == 4'h0) begin
                    call_nxt  = 1'b1;
                    vec_nxt   = {8'h00, 5'({1'b0, win_r} + 5'h01), 1'b0};
                    state_nxt = UIC_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            default: state_nxt = UIC_IDLE;
        endcase
        // Register writes; reserved bits drop out here
        if (i_io_wr) begin
            case (i_io_addr)
                // RQ23: reserved bits ignored
                ADDR_GLOBAL_EN: gen_en_nxt = i_io_wdata & GEN_EN_MASK;
                ADDR_EP_EN:     ep_en_nxt  = i_io_wdata & EP_EN_MASK;
                ADDR_STATUS: begin
                    run_nxt    = i_io_wdata[ST_RUN];
                    por_nxt    = i_io_wdata[ST_POR];
                    busrst_nxt = i_io_wdata[ST_BUSRST];
                    wdr_nxt    = i_io_wdata[ST_WDR];
                    // RQ6: blocked by bus activity
                    if (i_io_wdata[ST_SUSP] && !i_bus_active) begin
                        // RQ5: enter suspend
                        susp_nxt = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // RQ5: wake on request or bus
        if (susp_r && (i_bus_active || (|req))) begin
            susp_nxt = 1'b0;
        end
        // RQ8: bus reset flag, set wins
        if (bus_evt_r) begin
            busrst_nxt = 1'b1;
        end
        // RQ10: new event wins over clear
        if (|src_evt) begin
            irqp_nxt = 1'b1;
        end
        // RQ1: halt clears every status bit
        if (i_halt_instr) begin
            {irqp_nxt, wdr_nxt, busrst_nxt, por_nxt} = 4'h0;
            {susp_nxt, gie_nxt, run_nxt} = 3'b000;
        end
        // Register reads, answered on the next edge
        if (i_io_rd) begin
            case (i_io_addr)
                ADDR_GLOBAL_EN: rdata_nxt = gen_en_r;
                ADDR_EP_EN:     rdata_nxt = ep_en_r;
                ADDR_VECTOR:    rdata_nxt = (|req) ? {3'b000, win_now + 4'h1, 1'b0} : 8'h00;
                ADDR_STATUS:    rdata_nxt = status_w;
                default:        rdata_nxt = 8'h00;
            endcase
        end
        // RQ16: set wins over service clear
        pend_nxt = (pend_r & ~pend_clr) | src_evt;
        // RQ13: watchdog keeps power-on and bus flags
        if (wdt_fire_r) begin
            {irqp_nxt, wdr_nxt, susp_nxt, gie_nxt, run_nxt} = 5'b01001;
            gen_en_nxt = EN_RESET_VAL;
            ep_en_nxt  = EN_RESET_VAL;
            pend_nxt   = '0;
            state_nxt  = UIC_IDLE;
            push_nxt   = 1'b0;
            call_nxt   = 1'b0;
        end
    end

    // RQ7: power-on flag set
    // RQ11: power-up values
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            {irqp_r, wdr_r, busrst_r, por_r, susp_r, gie_r} <= STATUS_POR_VAL[7:2];
            run_r    <= STATUS_POR_VAL[ST_RUN];
            gen_en_r <= EN_RESET_VAL;
            ep_en_r  <= EN_RESET_VAL;
            pend_r   <= '0;
            state_r  <= UIC_IDLE;
            cnt_r    <= 4'h0;
            win_r    <= 4'h0;
            rdata_r  <= 8'h00;
            push_r   <= 1'b0;
            call_r   <= 1'b0;
            word_r   <= 16'h0000;
            vec_r    <= 14'h0000;
        end else begin
            {irqp_r, wdr_r, busrst_r, por_r} <= {irqp_nxt, wdr_nxt, busrst_nxt, por_nxt};
            {susp_r, gie_r, run_r} <= {susp_nxt, gie_nxt, run_nxt};
            gen_en_r <= gen_en_nxt;
            ep_en_r  <= ep_en_nxt;
            pend_r   <= pend_nxt;
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            win_r    <= win_nxt;
            rdata_r  <= rdata_nxt;
            push_r   <= push_nxt;
            call_r   <= call_nxt;
            word_r   <= word_nxt;
            vec_r    <= vec_nxt;
        end
    end

    // Outputs
    assign o_io_rdata    = rdata_r;
    assign o_run         = run_r;
    assign o_suspend     = susp_r;
    assign o_ack_busy    = (state_r != UIC_IDLE);
    assign o_stack_push  = push_r;
    assign o_stack_word  = word_r;
    assign o_call_strobe = call_r;
    assign o_call_vector = vec_r;
    assign o_wdt_reset   = wdt_fire_r;
    assign o_bus_reset   = bus_evt_r;

    // ==========================================================
    // Assertions
    property p_halt_clear;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_halt_instr && !wdt_fire_r) |=> (status_w == 8'h00);
    endproperty
    a_halt_clear: assert property (p_halt_clear) else $error("halt left status set"); // RQ1

    property p_gie_write;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_io_wr && i_io_addr == ADDR_STATUS && state_r == UIC_IDLE && !i_irq_off_instr
         && !i_irq_on_instr && !i_irq_return_instr && !i_halt_instr && !wdt_fire_r
         && !i_instr_done) |=> (gie_r == $past(gie_r));
    endproperty
    a_gie_write: assert property (p_gie_write) else $error("status write moved enable"); // RQ3

    property p_enable_instr;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_r == UIC_IDLE && i_irq_return_instr && !i_irq_off_instr && !i_halt_instr
         && !wdt_fire_r && !i_instr_done) |=> gie_r;
    endproperty
    a_enable_instr: assert property (p_enable_instr) else $error("return did not enable"); // RQ4

    property p_susp_block;
        @(posedge i_clk) disable iff (!i_resetn)
        (!susp_r && i_bus_active && i_io_wr && i_io_addr == ADDR_STATUS) |=> !susp_r;
    endproperty
    a_susp_block: assert property (p_susp_block) else $error("suspend taken on busy bus"); // RQ6

    property p_por_value;
        @(posedge i_clk) disable iff (!i_resetn)
        !$past(i_resetn) |-> (status_w == STATUS_POR_VAL);
    endproperty
    a_por_value: assert property (p_por_value) else $error("wrong power-up status"); // RQ11

    property p_bus_flag;
        @(posedge i_clk) disable iff (!i_resetn)
        (bus_evt_r && !i_halt_instr) |=> (busrst_r && pend_r[SRC_BUSRST]);
    endproperty
    a_bus_flag: assert property (p_bus_flag) else $error("bus reset not recorded"); // RQ8

    property p_wdt_value;
        @(posedge i_clk) disable iff (!i_resetn)
        wdt_fire_r |=> (wdr_r && run_r && !irqp_r && !gie_r && pend_r == '0
                        && por_r == $past(por_r));
    endproperty
    a_wdt_value: assert property (p_wdt_value) else $error("watchdog status wrong"); // RQ13

    property p_ack_order;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_r == UIC_DISABLE) |-> (!gie_r && $past(gie_r));
    endproperty
    a_ack_order: assert property (p_ack_order) else $error("enable not cleared first"); // RQ18

    property p_call_len;
        @(posedge i_clk) disable iff (!i_resetn || wdt_fire_r)
        (state_r == UIC_DISABLE) |-> ##1 o_stack_push ##9 o_call_strobe;
    endproperty
    a_call_len: assert property (p_call_len) else $error("call not ten cycles"); // RQ22

    // Pending bits that no acknowledge is clearing this cycle
    assign pend_keep = pend_r & ~pend_clr;

    property p_pend_hold;
        @(posedge i_clk) disable iff (!i_resetn)
        !wdt_fire_r |=> ((pend_r & $past(pend_keep)) == $past(pend_keep));
    endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("pending flop lost"); // RQ16

    c_ack_done: cover property (@(posedge i_clk) disable iff (!i_resetn) o_call_strobe);
    c_suspend:  cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(susp_r));
    c_wdt:      cover property (@(posedge i_clk) disable iff (!i_resetn) wdt_fire_r);
    c_bus_rst:  cover property (@(posedge i_clk) disable iff (!i_resetn) bus_evt_r);
endmodule

// ### tb/uic_core_model.sv
`timescale 1ns/1ps
// ==========================================================
// Processor core stand-in: retires one instruction every 4 cycles
module uic_core_model (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_run,
    input  wire logic        i_suspend,
    input  wire logic        i_ack_busy,
    input  wire logic        i_feed,
    output logic             o_instr_done,
    output logic      [13:0] o_pc,
    output logic             o_carry,
    output logic             o_zero,
    output logic             o_wdt_clear
);
    logic [1:0] cnt;

    // Stalls while halted, suspended or acknowledging, as a real core would
    // instruction completion boundary
    always @(posedge i_clk) begin
        o_instr_done <= 1'b0;
        o_wdt_clear  <= 1'b0;
        if (!i_resetn) begin
            cnt     <= 2'd0;
            o_pc    <= 14'h0000;
            o_carry <= 1'b0;
            o_zero  <= 1'b1;
        end else if (i_run && !i_suspend && !i_ack_busy) begin
            cnt <= cnt + 2'd1;
            if (cnt == 2'd3) begin
                o_instr_done <= 1'b1;
                o_wdt_clear  <= i_feed; // Firmware feeds watchdog when allowed
                o_pc         <= o_pc + 14'h0003;
                o_carry      <= ~o_carry;
                o_zero       <= o_carry;
            end
        end
    end
endmodule

// ### tb/irq_ctrl_and_cpu_status_tb.sv
`timescale 1ns/1ps
module irq_ctrl_and_cpu_status_tb import uic_pkg::*;;
    localparam int WDT = 200;
    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic        io_wr = 1'b0;
    logic        io_rd = 1'b0;
    logic [7:0]  io_addr = 8'h00;
    logic [7:0]  io_wdata = 8'h00;
    logic [7:0]  io_rdata;
    logic [3:0]  ins = 4'h0; // {halt, return, on, off}
    logic [11:0] src = 12'h000;
    logic        se0 = 1'b0;
    logic        bus_act = 1'b0;
    logic        feed = 1'b1;
    logic        startup = 1'b0;
    int          n_fire = 0;
    logic        done, carry, zero, wclr, run, susp, busy, push, call, wdt_rst, bus_rst;
    logic [13:0] pc, vec;
    logic [15:0] word;
    int          n_mismatch = 0;
    int          check_count = 0;

    always #12.5 i_clk = ~i_clk;

    // ==========================================================
    // Device and core model
    uic_irq_ctrl #(.WDT_CYCLES(WDT)) dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_io_wr(io_wr), .i_io_rd(io_rd),
        .i_io_addr(io_addr), .i_io_wdata(io_wdata), .o_io_rdata(io_rdata),
        .i_instr_done(done), .i_irq_off_instr(ins[0]), .i_irq_on_instr(ins[1]),
        .i_irq_return_instr(ins[2]), .i_halt_instr(ins[3]), .i_wdt_clear(wclr),
        .i_pc(pc), .i_carry_flag(carry), .i_zero_flag(zero), .i_src_event(src),
        .i_se0(se0), .i_bus_active(bus_act), .i_startup_active(startup),
        .o_run(run), .o_suspend(susp), .o_ack_busy(busy), .o_stack_push(push),
        .o_stack_word(word), .o_call_strobe(call), .o_call_vector(vec),
        .o_wdt_reset(wdt_rst), .o_bus_reset(bus_rst));
    uic_core_model core (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_run(run), .i_suspend(susp),
        .i_ack_busy(busy), .i_feed(feed), .o_instr_done(done), .o_pc(pc),
        .o_carry(carry), .o_zero(zero), .o_wdt_clear(wclr));

    // ==========================================================
    // Access tasks and comparisons
    task automatic tick();
        @(posedge i_clk);
        #1;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp, input string m);
        check_count++;
        if (got != exp) begin
            n_mismatch++;
            $display("BAD %0t %s count %0d exp %0d", $time, m, got, exp);
        end
    endtask
    task automatic io_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        io_wr <= 1'b1;
        io_addr <= a;
        io_wdata <= d;
        @(posedge i_clk);
        io_wr <= 1'b0;
    endtask
    task automatic io_check(input logic [7:0] a, input logic [7:0] exp, input string m);
        @(posedge i_clk);
        io_rd <= 1'b1;
        io_addr <= a;
        @(posedge i_clk);
        io_rd <= 1'b0;
        #1;
        chk_val({8'h00, io_rdata}, {8'h00, exp}, m);
    endtask
    task automatic pulse(input logic [3:0] i, input logic [11:0] s);
        @(posedge i_clk);
        ins <= i;
        src <= s;
        @(posedge i_clk);
        ins <= 4'h0;
        src <= 12'h000;
    endtask
    // Waits for an acknowledge and times it from busy to the call
    task automatic take_irq(input logic [13:0] exp_vec);
        int n;
        int k;
        for (k = 0; k < 100 && busy !== 1'b1; k++) tick();
        if (k == 100) begin
            chk_cnt(k, 0, "no ack");
            complete_run();
        end
        for (n = 0; n < 40 && call !== 1'b1; n++) begin
            if (push === 1'b1) chk_val(word, {pc, carry, zero}, "stack word");
            tick();
        end
        chk_cnt(n, 10, "call delay");
        chk_val({2'b00, vec}, {2'b00, exp_vec}, "vector");
    endtask
    // Bounded wait for a one-bit output to reach a level
    task automatic wait_for(ref logic sig, input logic lvl, input int lim, input string m);
        int k;
        for (k = 0; k < lim && sig !== lvl; k++) tick();
        if (k == lim) begin
            chk_cnt(k, 0, m);
            complete_run();
        end
        check_count++;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge i_clk);
        i_resetn <= 1'b1;
        io_check(ADDR_STATUS, 8'h11, "status after power-on");
        io_check(ADDR_GLOBAL_EN, 8'h00, "global enable reset");
        io_check(8'h30, 8'h00, "unmapped read");
        io_write(ADDR_GLOBAL_EN, 8'hFF);
        io_check(ADDR_GLOBAL_EN, 8'h77, "global enable mask");
        io_write(ADDR_EP_EN, 8'hFF);
        io_check(ADDR_EP_EN, 8'h1F, "endpoint enable mask");
        // Bit 1 kept zero; a one at bit 2 must not enable
        io_write(ADDR_STATUS, 8'h05);
        io_check(ADDR_STATUS, 8'h01, "sense bit not writable");
        pulse(4'h2, 12'h000);
        io_check(ADDR_STATUS, 8'h05, "enable instruction");
        pulse(4'h1, 12'h000);
        io_check(ADDR_STATUS, 8'h01, "disable instruction");
        // Two sources at once while masked, then service by priority
        pulse(4'h0, 12'h802);
        io_check(ADDR_STATUS, 8'h81, "pending flag");
        io_check(ADDR_VECTOR, 8'h04, "highest pending vector");
        pulse(4'h2, 12'h000);
        take_irq(14'h0004);
        io_check(ADDR_STATUS, 8'h01, "after ack");
        pulse(4'h4, 12'h000);
        take_irq(14'h0018);
        io_check(ADDR_VECTOR, 8'h00, "nothing left");
        // Reserved source never requests
        pulse(4'h0, 12'h100);
        io_check(ADDR_VECTOR, 8'h00, "unenabled source");
        io_check(ADDR_STATUS, 8'h81, "pending seen");
        // Suspend refused under bus activity, then taken and woken
        @(posedge i_clk);
        bus_act <= 1'b1;
        io_write(ADDR_STATUS, 8'h09);
        io_check(ADDR_STATUS, 8'h81, "suspend refused");
        @(posedge i_clk);
        bus_act <= 1'b0;
        io_write(ADDR_STATUS, 8'h09);
        tick();
        chk_val({15'h0, susp}, 16'h0001, "suspended");
        pulse(4'h0, 12'h004);
        wait_for(susp, 1'b0, 10, "no wake");
        io_check(ADDR_STATUS, 8'h81, "after wake");
        // Bus reset of 500 cycles on the upstream port
        @(posedge i_clk);
        se0 <= 1'b1;
        repeat (500) @(posedge i_clk);
        se0 <= 1'b0;
        wait_for(bus_rst, 1'b1, 10, "no bus reset");
        io_check(ADDR_STATUS, 8'hA1, "bus reset flag");
        // Watchdog keeps power-on and bus reset flags
        io_write(ADDR_STATUS, 8'h31);
        feed <= 1'b0;
        wait_for(wdt_rst, 1'b1, 2 * WDT, "no watchdog");
        tick();
        @(posedge i_clk);
        feed <= 1'b1;
        io_check(ADDR_STATUS, 8'h71, "watchdog status");
        io_check(ADDR_GLOBAL_EN, 8'h00, "enables after watchdog");
        // Halt clears the status register; only the watchdog restarts the core
        pulse(4'h8, 12'h000);
        io_check(ADDR_STATUS, 8'h00, "halt status");
        chk_val({15'h0, run}, 16'h0000, "halted");
        wait_for(wdt_rst, 1'b1, 2 * WDT, "halt never ends");
        tick();
        io_check(ADDR_STATUS, 8'h41, "restart after halt");
        // Start-up interval: an upstream zero holds the watchdog off
        @(posedge i_clk);
        startup <= 1'b1;
        feed    <= 1'b0;
        se0     <= 1'b1;
        repeat (2 * WDT) begin
            tick();
            if (wdt_rst === 1'b1) n_fire++;
        end
        chk_cnt(n_fire, 0, "start-up abort");
        @(posedge i_clk);
        startup <= 1'b0;
        se0     <= 1'b0;
        feed    <= 1'b1;
        complete_run();
    end
endmodule
